// >>> src/mppwm_top.sv
// Contract
// - Eight independent outputs from one shared period counter and own toggle points.
// - Sixteen-bit counter sets cycle length; programmed terminal count defines period.
// - Counter advances each clock or after optional eight-bit prescaler division.
// - Each output supports up to four pulses, eight toggle edges per cycle.
// - Output inverts when counter value equals one of its toggle values.
// - Each output starts every cycle at its configured initial level.
// - Each output has an enable; disabled outputs do not show the waveform.
// - Run continuously while enabled, or run 1 to 255 cycles then stop.
// - Sequence starts on software command or external trigger, per configuration.
//
// The APB register port and the placing of the registers are this design's own decisions.
`include "mppwm_regs.svh"
module mppwm_top #(
  parameter int CHANNELS = 8,
  parameter int EDGES    = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                trig_in,
  output logic      [CHANNELS-1:0] pwm_out,
  output logic                     irq
);
  mppwm_pkg::mppwm_cfg_t     cfg;
  mppwm_pkg::mppwm_state_t   state;
  mppwm_pkg::mppwm_state_t   next_state;
  mppwm_pkg::mppwm_apb_req_t req;
  logic [15:0] count;
  logic [7:0]  pre_cnt;
  logic [7:0]  cycles_left;
  logic [1:0]  status;
  logic [1:0]  irq_mask;
  logic [15:0] toggle_mem [CHANNELS*EDGES];
  logic        trig_q;

  logic wr_en;
  logic rd_en;
  logic sel_ctrl;
  logic sel_period;
  logic sel_pre;
  logic sel_rep;
  logic sel_init;
  logic sel_outen;
  logic sel_status;
  logic sel_mask;
  logic sel_state;
  logic sel_tog;
  logic mapped;
  logic [5:0] tog_idx;
  logic sw_start;
  logic trig_rise;
  logic start_evt;
  logic tick;
  logic term;
  logic cycle_end;
  logic last_cycle;
  logic done_evt;
  logic reload;
  logic running;
  logic [31:0] rd_mux;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign pready  = 1'b1;
  assign wr_en   = req.psel & req.penable & req.pwrite;
  assign rd_en   = req.psel & ~req.penable & ~req.pwrite;

  assign sel_ctrl   = req.paddr == `MPPWM_OFS_CTRL;
  assign sel_period = req.paddr == `MPPWM_OFS_PERIOD;
  assign sel_pre    = req.paddr == `MPPWM_OFS_PRESCALE;
  assign sel_rep    = req.paddr == `MPPWM_OFS_REPEAT;
  assign sel_init   = req.paddr == `MPPWM_OFS_INIT;
  assign sel_outen  = req.paddr == `MPPWM_OFS_OUTEN;
  assign sel_status = req.paddr == `MPPWM_OFS_STATUS;
  assign sel_mask   = req.paddr == `MPPWM_OFS_IRQMASK;
  assign sel_state  = req.paddr == `MPPWM_OFS_STATE;
  assign sel_tog    = (req.paddr >= `MPPWM_OFS_TOGGLE) && (req.paddr <= `MPPWM_OFS_TOG_END)
                      && (req.paddr[1:0] == 2'h0);
  assign tog_idx    = req.paddr[`MPPWM_TOG_IDX_LSB +: 6];
  assign mapped     = sel_ctrl | sel_period | sel_pre | sel_rep | sel_init | sel_outen
                      | sel_status | sel_mask | sel_state | sel_tog;
  assign pslverr    = req.psel & req.penable & ~mapped;

  // Start sources
  assign sw_start  = wr_en & sel_ctrl & pwdata[`MPPWM_CTRL_START];
  assign trig_rise = trig_in & ~trig_q;
  assign start_evt = cfg.trig_sel ? trig_rise : sw_start;

  // Timebase
  assign tick       = running & (~cfg.pre_en | (pre_cnt == cfg.prescale));
  assign term       = count == cfg.period;
  assign cycle_end  = tick & term;
  assign last_cycle = ~cfg.cont & (cycles_left <= 8'h01);
  assign done_evt   = cycle_end & last_cycle;
  assign running    = state == mppwm_pkg::MPPWM_RUNNING;
  assign reload     = (state == mppwm_pkg::MPPWM_ARMED) | (cycle_end & ~last_cycle);

  always_comb begin
    next_state = state;
    case (state)
      mppwm_pkg::MPPWM_IDLE: begin
        if (cfg.run && start_evt) begin
          next_state = mppwm_pkg::MPPWM_ARMED;
        end
      end
      mppwm_pkg::MPPWM_ARMED: begin
        next_state = mppwm_pkg::MPPWM_RUNNING;
      end
      mppwm_pkg::MPPWM_RUNNING: begin
        if (!cfg.run || done_evt) begin
          next_state = mppwm_pkg::MPPWM_IDLE;
        end
      end
      default: begin
        next_state = mppwm_pkg::MPPWM_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state  <= mppwm_pkg::MPPWM_IDLE;
      trig_q <= 1'b0;
    end else begin
      state  <= next_state;
      trig_q <= trig_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !running) begin
      pre_cnt <= 8'h00;
    end else if (tick) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !running) begin
      count <= 16'h0000;
    end else if (cycle_end) begin
      count <= 16'h0000;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cycles_left <= `MPPWM_REPEAT_RST;
    end else if (state == mppwm_pkg::MPPWM_ARMED) begin
      cycles_left <= cfg.repeat_cnt;
    end else if (cycle_end && cycles_left != 8'h00) begin
      cycles_left <= cycles_left - 8'h01;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg <= '{run: 1'b0, pre_en: 1'b0, cont: 1'b0, trig_sel: 1'b0,
               period: `MPPWM_PERIOD_RST, prescale: 8'h00,
               repeat_cnt: `MPPWM_REPEAT_RST, init_lvl: 8'h00, out_en: 8'h00};
      irq_mask <= 2'h0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        cfg.run      <= pwdata[`MPPWM_CTRL_RUN];
        cfg.pre_en   <= pwdata[`MPPWM_CTRL_PRE_EN];
        cfg.cont     <= pwdata[`MPPWM_CTRL_CONT];
        cfg.trig_sel <= pwdata[`MPPWM_CTRL_TRIG_SEL];
      end
      if (sel_period) begin
        cfg.period <= pwdata[15:0];
      end
      if (sel_pre) begin
        cfg.prescale <= pwdata[7:0];
      end
      if (sel_rep && pwdata[7:0] != 8'h00) begin
        cfg.repeat_cnt <= pwdata[7:0];
      end
      if (sel_init) begin
        cfg.init_lvl <= pwdata[7:0];
      end
      if (sel_outen) begin
        cfg.out_en <= pwdata[7:0];
      end
      if (sel_mask) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CHANNELS*EDGES; i++) begin
        toggle_mem[i] <= `MPPWM_TOG_RST;
      end
    end else if (wr_en && sel_tog) begin
      toggle_mem[tog_idx] <= pwdata[15:0];
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= 2'h0;
    end else begin
      status[`MPPWM_ST_DONE] <= done_evt | (status[`MPPWM_ST_DONE]
        & ~(wr_en & sel_status & pwdata[`MPPWM_ST_DONE]));
      status[`MPPWM_ST_CYCLE] <= cycle_end | (status[`MPPWM_ST_CYCLE]
        & ~(wr_en & sel_status & pwdata[`MPPWM_ST_CYCLE]));
    end
  end

  assign irq = |(status & irq_mask);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux = {28'h0, cfg.trig_sel, cfg.cont, cfg.pre_en, cfg.run};
    end else if (sel_period) begin
      rd_mux = {16'h0, cfg.period};
    end else if (sel_pre) begin
      rd_mux = {24'h0, cfg.prescale};
    end else if (sel_rep) begin
      rd_mux = {24'h0, cfg.repeat_cnt};
    end else if (sel_init) begin
      rd_mux = {24'h0, cfg.init_lvl};
    end else if (sel_outen) begin
      rd_mux = {24'h0, cfg.out_en};
    end else if (sel_status) begin
      rd_mux = {30'h0, status};
    end else if (sel_mask) begin
      rd_mux = {30'h0, irq_mask};
    end else if (sel_state) begin
      rd_mux = {6'h0, cycles_left, running, 1'b0, count};
    end else if (sel_tog) begin
      rd_mux = {16'h0, toggle_mem[tog_idx]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_mux;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    logic [EDGES*16-1:0] tog_flat;
    for (genvar e = 0; e < EDGES; e++) begin : g_e
      assign tog_flat[e*16 +: 16] = toggle_mem[c*EDGES + e];
    end
    mppwm_channel #(.EDGES(EDGES)) u_ch (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .count    (count),
      .tick     (tick),
      .reload   (reload),
      .init_lvl (cfg.init_lvl[c]),
      .out_en   (cfg.out_en[c]),
      .toggles  (tog_flat),
      .pwm_out  (pwm_out[c])
    );
  end

  sequence s_final_end;
    done_evt;
  endsequence

  sequence s_armed;
    state == mppwm_pkg::MPPWM_ARMED;
  endsequence

  sequence s_first_count;
    running && count == 16'h0000;
  endsequence

  sequence s_wrap;
    cycle_end && !last_cycle && cfg.run;
  endsequence

  // Sequencing and repeat count
  AST_DONE_TO_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_final_end |=> state == mppwm_pkg::MPPWM_IDLE)
    else $error("no stop after last cycle");
  AST_START: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == mppwm_pkg::MPPWM_IDLE && cfg.run && start_evt |=> ##1 running)
    else $error("start ignored");
  AST_TRIG_ONLY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == mppwm_pkg::MPPWM_IDLE && cfg.trig_sel && !trig_rise |=> !running)
    else $error("started without trigger");
  AST_ARMED_ONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_armed |=> s_first_count)
    else $error("no clean start after arming");
  AST_REPEAT_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_armed |=> cycles_left == $past(cfg.repeat_cnt))
    else $error("repeat count not loaded");
  AST_CYCLES_DEC: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_wrap and !cfg.cont |=> cycles_left == $past(cycles_left) - 8'h01)
    else $error("repeat count not consumed");
  AST_REPEAT_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && sel_rep && pwdata[7:0] == 8'h00 |=> cfg.repeat_cnt == $past(cfg.repeat_cnt))
    else $error("zero repeat count accepted");
  AST_CONT_RUN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    running && cfg.cont && cfg.run |=> running)
    else $error("continuous stopped");
  AST_RUN_STOP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    running && !cfg.run |=> !running)
    else $error("clearing run did not stop");

  // Timebase
  AST_WRAP_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_wrap |=> s_first_count)
    else $error("no wrap");
  AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tick && !term |=> count == $past(count) + 16'h0001)
    else $error("bad step");
  AST_IDLE_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !running |=> count == 16'h0000)
    else $error("counter moved while stopped");
  AST_NOPRE_TICK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    running && !cfg.pre_en && !term |=> count != $past(count))
    else $error("missing tick");
  AST_PRE_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tick && cfg.pre_en && cfg.prescale != 8'h00
    |=> !tick || !cfg.pre_en || cfg.prescale == 8'h00)
    else $error("prescaler skipped");

  // Status, interrupt and outputs
  AST_DONE_FLAG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_final_end |=> status[`MPPWM_ST_DONE])
    else $error("done flag not set");
  AST_STATUS_STICKY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    status[`MPPWM_ST_DONE] && !(wr_en && sel_status && pwdata[`MPPWM_ST_DONE])
    |=> status[`MPPWM_ST_DONE])
    else $error("done flag lost");
  AST_CYCLE_FLAG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cycle_end |=> status[`MPPWM_ST_CYCLE])
    else $error("cycle flag not set");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_final_end |=> irq || !irq_mask[`MPPWM_ST_DONE])
    else $error("irq missing");
  AST_RELOAD_INIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reload |=> pwm_out == CHANNELS'($past(cfg.init_lvl) & $past(cfg.out_en)))
    else $error("outputs not at initial level");
  AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_en && !mapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

// >>> common/mppwm_regs.svh
`ifndef MPPWM_REGS_SVH
`define MPPWM_REGS_SVH
`define MPPWM_OFS_CTRL      12'h000
`define MPPWM_OFS_PERIOD    12'h004
`define MPPWM_OFS_PRESCALE  12'h008
`define MPPWM_OFS_REPEAT    12'h00C
`define MPPWM_OFS_INIT      12'h010
`define MPPWM_OFS_OUTEN     12'h014
`define MPPWM_OFS_STATUS    12'h018
`define MPPWM_OFS_IRQMASK   12'h01C
`define MPPWM_OFS_STATE     12'h020
`define MPPWM_OFS_TOGGLE    12'h100
`define MPPWM_OFS_TOG_END   12'h1FC
`define MPPWM_CTRL_RUN      0
`define MPPWM_CTRL_PRE_EN   1
`define MPPWM_CTRL_CONT     2
`define MPPWM_CTRL_TRIG_SEL 3
`define MPPWM_CTRL_START    4
`define MPPWM_ST_DONE       0
`define MPPWM_ST_CYCLE      1
`define MPPWM_PERIOD_RST    16'hFFFF
`define MPPWM_REPEAT_RST    8'h01
`define MPPWM_TOG_RST       16'hFFFF
`define MPPWM_TOG_IDX_LSB   2
`define MPPWM_TOG_EDGE_W    3
`define MPPWM_TOG_CH_LSB    5
`endif

// >>> common/mppwm_pkg.sv
package mppwm_pkg;
  typedef enum logic [1:0] {
    MPPWM_IDLE,
    MPPWM_ARMED,
    MPPWM_RUNNING
  } mppwm_state_t;

  typedef struct packed {
    logic        run;
    logic        pre_en;
    logic        cont;
    logic        trig_sel;
    logic [15:0] period;
    logic [7:0]  prescale;
    logic [7:0]  repeat_cnt;
    logic [7:0]  init_lvl;
    logic [7:0]  out_en;
  } mppwm_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mppwm_apb_req_t;
endpackage

// >>> src/mppwm_channel.sv
`include "mppwm_regs.svh"
module mppwm_channel #(
  parameter int EDGES = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [15:0]           count,
  input  wire logic                  tick,
  input  wire logic                  reload,
  input  wire logic                  init_lvl,
  input  wire logic                  out_en,
  input  wire logic [EDGES*16-1:0]   toggles,
  output logic                       pwm_out
);
  logic level;
  logic hit;

  function automatic logic any_match(input logic [15:0] c,
                                     input logic [EDGES*16-1:0] t);
    logic m;
    m = 1'b0;
    for (int i = 0; i < EDGES; i++) begin
      m = m | (t[i*16 +: 16] == c);
    end
    return m;
  endfunction

  assign hit = tick & any_match(count, toggles);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level <= 1'b0;
    end else if (reload) begin
      level <= init_lvl;
    end else if (hit) begin
      level <= ~level;
    end
  end

  // Gated output held low when disabled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= out_en & (reload ? init_lvl : (hit ? ~level : level));
    end
  end

  AST_DISABLED_LOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !out_en |=> !pwm_out) else $error("disabled output not low");
endmodule

// >>> verif/mppwm_load.sv
module mppwm_load (
  input wire logic       sys_clk,
  input wire logic       clear,
  input wire logic [7:0] pwm_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int         rises[8];
  int         hi_w[8];
  int         per[8];
  int         hi_cnt[8];
  int         since[8];
  logic [7:0] prev = 8'h00;

  // Rising-edge count, last high width and last rise-to-rise spacing per load
  always @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      since[i]++;
      if (clear) begin
        rises[i] = 0;
        hi_w[i] = 0;
        per[i] = 0;
        hi_cnt[i] = 0;
      end else if (pwm_out[i] === 1'b1) begin
        hi_cnt[i]++;
        if (prev[i] !== 1'b1) begin
          rises[i]++;
          per[i] = since[i];
          since[i] = 0;
        end
      end else if (prev[i] === 1'b1) begin
        hi_w[i] = hi_cnt[i];
        hi_cnt[i] = 0;
      end
    end
    prev = pwm_out;
  end
endmodule

// >>> verif/multi_pulse_pwm_tb.sv
`include "mppwm_regs.svh"
module multi_pulse_pwm_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk  = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic        trig_in  = 1'b0;
  logic        load_clr = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pwm_out;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  mppwm_top mppwm_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .pwm_out(pwm_out), .irq(irq));
  mppwm_load mppwm_load_inst (.sys_clk(sys_clk), .clear(load_clr), .pwm_out(pwm_out));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic tog(input int ch, input int e, input logic [15:0] v);
    wr(`MPPWM_OFS_TOGGLE + 12'(4 * (ch * 8 + e)), {16'h0000, v});
  endtask

  task automatic clr_load();
    @(posedge sys_clk);
    load_clr <= 1'b1;
    @(posedge sys_clk);
    load_clr <= 1'b0;
  endtask

  task automatic wait_done();
    for (int n = 0; n < 300; n++) begin
      apb(1'b0, `MPPWM_OFS_STATUS, 32'h0);
      if (rd[0] === 1'b1) break;
    end
  endtask

  task automatic t_reset();
    chk("pwm idle", 32'h0, {24'h0, pwm_out});
    chk("irq idle", 32'h0, {31'h0, irq});
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b0, `MPPWM_OFS_STATE, 32'h0);
    chk("state reset", 32'h0004_0000, rd);
    apb(1'b0, `MPPWM_OFS_PERIOD, 32'h0);
    chk("period reset", 32'h0000_FFFF, rd);
    apb(1'b0, `MPPWM_OFS_REPEAT, 32'h0);
    chk("repeat reset", 32'h1, rd);
    wr(`MPPWM_OFS_REPEAT, 32'h0);
    apb(1'b0, `MPPWM_OFS_REPEAT, 32'h0);
    chk("repeat zero kept", 32'h1, rd);
    apb(1'b0, `MPPWM_OFS_TOGGLE, 32'h0);
    chk("toggle reset", 32'h0000_FFFF, rd);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_finite();
    wr(`MPPWM_OFS_CTRL, 32'h0);
    wr(`MPPWM_OFS_PERIOD, 32'h9);
    wr(`MPPWM_OFS_REPEAT, 32'h3);
    wr(`MPPWM_OFS_INIT, 32'h4);
    wr(`MPPWM_OFS_OUTEN, 32'h7);
    wr(`MPPWM_OFS_IRQMASK, 32'h1);
    tog(0, 0, 16'h0002);
    tog(0, 1, 16'h0005);
    tog(3, 0, 16'h0002);
    tog(3, 1, 16'h0005);
    for (int e = 0; e < 8; e++) tog(1, e, 16'(e + 1));
    clr_load();
    wr(`MPPWM_OFS_CTRL, 32'h01);
    wr(`MPPWM_OFS_CTRL, 32'h11);
    repeat (8) @(posedge sys_clk);
    chk("init level", 32'h1, {31'h0, pwm_out[2]});
    wait_done();
    chk("ch0 pulses", 32'd3, mppwm_load_inst.rises[0]);
    chk("ch0 width", 32'd3, mppwm_load_inst.hi_w[0]);
    chk("ch0 spacing", 32'd10, mppwm_load_inst.per[0]);
    chk("ch1 pulses", 32'd12, mppwm_load_inst.rises[1]);
    chk("ch3 masked", 32'd0, mppwm_load_inst.rises[3]);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(`MPPWM_OFS_STATUS, 32'h3);
    @(negedge sys_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask

  task automatic t_prescale();
    wr(`MPPWM_OFS_CTRL, 32'h0);
    wr(`MPPWM_OFS_PRESCALE, 32'h1);
    wr(`MPPWM_OFS_REPEAT, 32'h2);
    clr_load();
    wr(`MPPWM_OFS_CTRL, 32'h03);
    wr(`MPPWM_OFS_CTRL, 32'h13);
    wait_done();
    chk("slow width", 32'd6, mppwm_load_inst.hi_w[0]);
    chk("slow spacing", 32'd20, mppwm_load_inst.per[0]);
    wr(`MPPWM_OFS_STATUS, 32'h3);
  endtask

  task automatic t_trigger();
    wr(`MPPWM_OFS_CTRL, 32'h0);
    wr(`MPPWM_OFS_REPEAT, 32'h1);
    clr_load();
    wr(`MPPWM_OFS_CTRL, 32'h09);
    repeat (30) @(posedge sys_clk);
    chk("no trigger yet", 32'd0, mppwm_load_inst.rises[0]);
    trig_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    trig_in <= 1'b0;
    wait_done();
    chk("trigger run", 32'd1, mppwm_load_inst.rises[0]);
    wr(`MPPWM_OFS_STATUS, 32'h3);
  endtask

  task automatic t_cont();
    wr(`MPPWM_OFS_CTRL, 32'h0);
    clr_load();
    wr(`MPPWM_OFS_CTRL, 32'h05);
    wr(`MPPWM_OFS_CTRL, 32'h15);
    repeat (80) @(posedge sys_clk);
    chk("free run", 32'h1, {31'h0, mppwm_load_inst.rises[0] > 5});
    wr(`MPPWM_OFS_CTRL, 32'h0);
    clr_load();
    repeat (30) @(posedge sys_clk);
    chk("stopped", 32'd0, mppwm_load_inst.rises[0]);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_finite();
    t_prescale();
    t_trigger();
    t_cont();
    tally_and_finish();
  end

  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
